/* File: hdl/micp_pkg.sv */
`default_nettype none
package micp_pkg;
	// link field widths
	localparam int ADDR_W   = 22;
	localparam int BANK_W   = 3;
	localparam int DATA_W   = 18;
	localparam int WR_BEATS = 2;

	// timing: system clock and the link clock made by the controller end
	localparam int CLK_PERIOD_PS  = 4000;
	localparam int LINK_PERIOD_NS = 64;
	localparam int QTR_CYC        = (LINK_PERIOD_NS * 1000) / (4 * CLK_PERIOD_PS);
	localparam int FAULT_CYC      = 4;

	// reset values
	localparam logic [ADDR_W-1:0] CFG_RST = 22'h000000;

	// positions of the command pins in a packed triple
	localparam int PIN_CS  = 2;
	localparam int PIN_WE  = 1;
	localparam int PIN_REF = 0;

	typedef enum logic [2:0] {
		MICP_NOP      = 3'b000,
		MICP_READ     = 3'b001,
		MICP_WRITE    = 3'b010,
		MICP_REFRESH  = 3'b011,
		MICP_CFG_LOAD = 3'b100
	} micp_cmd_t;

	// command from {select_n, write_n, refresh_n}; deselect gives no command
	function automatic micp_cmd_t micp_decode(input logic [2:0] pins);
		micp_cmd_t k;
		k = MICP_NOP;
		if (!pins[PIN_CS]) begin
			case ({pins[PIN_WE], pins[PIN_REF]})
				2'h3: k = MICP_READ;
				2'h2: k = MICP_REFRESH;
				2'h1: k = MICP_WRITE;
				default: k = MICP_CFG_LOAD;
			endcase
		end
		return k;
	endfunction

	// pin levels that carry a command
	function automatic logic [2:0] micp_encode(input micp_cmd_t k);
		logic [2:0] p;
		p = 3'h7;
		case (k)
			MICP_READ:     p = 3'h3;
			MICP_WRITE:    p = 3'h1;
			MICP_REFRESH:  p = 3'h2;
			MICP_CFG_LOAD: p = 3'h0;
			default:       p = 3'h7;
		endcase
		return p;
	endfunction
endpackage
`default_nettype wire

/* File: hdl/micp_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface micp_link_if;
	import micp_pkg::*;
	logic              cmd_clock_true;
	logic              cmd_clock_comp;
	logic              wdata_strobe_clock;
	logic              wdata_strobe_clock_comp;
	logic [ADDR_W-1:0] row_col_select_lines;
	logic [BANK_W-1:0] bank_select_lines;
	logic              dev_select_n;
	logic              write_cmd_n;
	logic              refresh_cmd_n;
	logic [DATA_W-1:0] write_data_in;
	logic              write_beat_mask;

	modport ctrl (
		output cmd_clock_true,
		output cmd_clock_comp,
		output wdata_strobe_clock,
		output wdata_strobe_clock_comp,
		output row_col_select_lines,
		output bank_select_lines,
		output dev_select_n,
		output write_cmd_n,
		output refresh_cmd_n,
		output write_data_in,
		output write_beat_mask
	);

	modport mem (
		input cmd_clock_true,
		input cmd_clock_comp,
		input wdata_strobe_clock,
		input wdata_strobe_clock_comp,
		input row_col_select_lines,
		input bank_select_lines,
		input dev_select_n,
		input write_cmd_n,
		input refresh_cmd_n,
		input write_data_in,
		input write_beat_mask
	);
endinterface
`default_nettype wire

/* File: hdl/micp_ctrl_end.sv */
`timescale 1ns/1ps
`default_nettype none
module micp_ctrl_end #(
	parameter int QTR_CYC  = micp_pkg::QTR_CYC,
	parameter int WR_BEATS = micp_pkg::WR_BEATS
) (
	input  wire logic                                    clk_sys,
	input  wire logic                                    arst_n,
	input  wire logic                                    ce,
	input  wire logic                                    req_valid,
	output logic                                         req_ready,
	input  wire micp_pkg::micp_cmd_t                     req_kind,
	input  wire logic [micp_pkg::BANK_W-1:0]             req_bank,
	input  wire logic [micp_pkg::ADDR_W-1:0]             req_addr,
	input  wire logic [WR_BEATS*micp_pkg::DATA_W-1:0]    req_wdata,
	input  wire logic [WR_BEATS-1:0]                     req_wmask,
	output logic                                         busy,
	micp_link_if.ctrl                                    link
);
	import micp_pkg::*;

	localparam int QC_W = $clog2(QTR_CYC + 1);
	localparam int BC_W = $clog2(WR_BEATS + 1);

	typedef enum logic [0:0] {
		MICP_CS_IDLE  = 1'b0,
		MICP_CS_BURST = 1'b1
	} micp_cstate_t;

	logic [QC_W-1:0]            qcnt_reg, qcnt_next;
	logic [1:0]                 quarter_reg, quarter_next;
	logic                       cclk_reg, cclk_next;
	logic                       sclk_reg, sclk_next;
	logic [2:0]                 pins_reg, pins_next;
	logic [BANK_W-1:0]          bank_reg, bank_next;
	logic [ADDR_W-1:0]          addr_reg, addr_next;
	logic [DATA_W-1:0]          dout_reg, dout_next;
	logic                       mout_reg, mout_next;
	logic [WR_BEATS*DATA_W-1:0] wsh_reg, wsh_next;
	logic [WR_BEATS-1:0]        msh_reg, msh_next;
	logic [BC_W-1:0]            left_reg, left_next;
	micp_cstate_t               state_reg, state_next;
	logic                       tick;
	logic                       to_q0;
	logic                       to_q2;

	// quarter ticks of the link period; commands move at the cmd clock fall
	assign tick      = ce && (qcnt_reg == QC_W'(QTR_CYC - 1));
	assign to_q0     = tick && (quarter_reg == 2'h3);
	assign to_q2     = tick && (quarter_reg == 2'h1);
	assign req_ready = to_q2 && (state_reg == MICP_CS_IDLE);
	assign busy      = (state_reg == MICP_CS_BURST);

	// pins: both halves of each clock pair always driven
	assign link.cmd_clock_true          = cclk_reg;
	assign link.cmd_clock_comp          = ~cclk_reg;
	assign link.wdata_strobe_clock      = sclk_reg;
	assign link.wdata_strobe_clock_comp = ~sclk_reg;
	assign link.dev_select_n            = pins_reg[PIN_CS];
	assign link.write_cmd_n             = pins_reg[PIN_WE];
	assign link.refresh_cmd_n           = pins_reg[PIN_REF];
	assign link.bank_select_lines       = bank_reg;
	assign link.row_col_select_lines    = addr_reg;
	assign link.write_data_in           = dout_reg;
	assign link.write_beat_mask         = mout_reg;

	// divider, command launch and write beat launch
	always_comb begin
		qcnt_next    = qcnt_reg;
		quarter_next = quarter_reg;
		cclk_next    = cclk_reg;
		sclk_next    = sclk_reg;
		pins_next    = pins_reg;
		bank_next    = bank_reg;
		addr_next    = addr_reg;
		dout_next    = dout_reg;
		mout_next    = mout_reg;
		wsh_next     = wsh_reg;
		msh_next     = msh_reg;
		left_next    = left_reg;
		state_next   = state_reg;
		if (ce) begin
			qcnt_next = tick ? '0 : qcnt_reg + QC_W'(1);
		end
		if (tick) begin
			quarter_next = quarter_reg + 2'h1;
			cclk_next    = (quarter_next == 2'h0) || (quarter_next == 2'h1);
			sclk_next    = (quarter_next == 2'h1) || (quarter_next == 2'h2);
		end
		// command held a full period, centred on the cmd clock rise
		if (to_q2) begin
			pins_next = 3'h7;
			if (req_valid && req_ready) begin
				pins_next = micp_encode(req_kind);
				bank_next = req_bank;
				addr_next = req_addr;
				if (req_kind == MICP_WRITE) begin
					wsh_next   = req_wdata;
					msh_next   = req_wmask;
					left_next  = BC_W'(WR_BEATS);
					state_next = MICP_CS_BURST;
				end
			end
		end
		// one word and one mask per strobe edge, changing between edges
		if ((to_q0 || to_q2) && (state_reg == MICP_CS_BURST)) begin
			dout_next = wsh_reg[DATA_W-1:0];
			mout_next = msh_reg[0];
			wsh_next  = wsh_reg >> DATA_W;
			msh_next  = msh_reg >> 1;
			left_next = left_reg - BC_W'(1);
			if (left_reg == BC_W'(1)) begin
				state_next = MICP_CS_IDLE;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			qcnt_reg    <= '0;
			quarter_reg <= 2'h3;
			cclk_reg    <= 1'b0;
			sclk_reg    <= 1'b0;
			pins_reg    <= 3'h7;
			bank_reg    <= '0;
			addr_reg    <= '0;
			dout_reg    <= '0;
			mout_reg    <= 1'b0;
			wsh_reg     <= '0;
			msh_reg     <= '0;
			left_reg    <= '0;
			state_reg   <= MICP_CS_IDLE;
		end else begin
			qcnt_reg    <= qcnt_next;
			quarter_reg <= quarter_next;
			cclk_reg    <= cclk_next;
			sclk_reg    <= sclk_next;
			pins_reg    <= pins_next;
			bank_reg    <= bank_next;
			addr_reg    <= addr_next;
			dout_reg    <= dout_next;
			mout_reg    <= mout_next;
			wsh_reg     <= wsh_next;
			msh_reg     <= msh_next;
			left_reg    <= left_next;
			state_reg   <= state_next;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/micp_mem_end.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - address and command taken at cmd clock rise
// - read/write take address as row/column location
// - config load stores address as settings
// - bank lines choose the command's bank
// - decoder enabled only while select is low
// - deselect ignores commands, running bursts continue
// - write data sampled on both strobe edges
// - all data bits use one strobe pair
// - masked beat is not stored
// - mask sampled per beat, both edges
// - controller drives both halves of clocks
// - command from write, refresh and select
module micp_mem_end #(
	parameter int WR_BEATS  = micp_pkg::WR_BEATS,
	parameter int FAULT_CYC = micp_pkg::FAULT_CYC
) (
	input  wire logic                                    clk_sys,
	input  wire logic                                    arst_n,
	input  wire logic                                    ce,
	micp_link_if.mem                                     link,
	output logic                                         cmd_valid,
	output micp_pkg::micp_cmd_t                          cmd_kind,
	output logic [micp_pkg::BANK_W-1:0]                  cmd_bank,
	output logic [micp_pkg::ADDR_W-1:0]                  cmd_row_col,
	output logic                                         cfg_load,
	output logic [micp_pkg::ADDR_W-1:0]                  cfg_settings,
	output logic                                         wbeat_valid,
	output logic                                         wbeat_store,
	output logic [micp_pkg::DATA_W-1:0]                  wbeat_data,
	output logic [$clog2(WR_BEATS+1)-1:0]                wbeat_index,
	output logic [micp_pkg::BANK_W-1:0]                  wbeat_bank,
	output logic [micp_pkg::ADDR_W-1:0]                  wbeat_row_col,
	output logic                                         write_active,
	output logic                                         clk_fault
);
	import micp_pkg::*;

	localparam int SYNC_W = 7 + BANK_W + ADDR_W + DATA_W + 1;
	localparam int BC_W   = $clog2(WR_BEATS + 1);
	localparam int FC_W   = $clog2(FAULT_CYC + 1);

	typedef enum logic [0:0] {
		MICP_WS_IDLE  = 1'b0,
		MICP_WS_BURST = 1'b1
	} micp_wstate_t;

	// synchroniser and edge history
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic              cclk_prev_reg, cclk_prev_next;
	logic              sclk_prev_reg, sclk_prev_next;

	// unpacked, synchronised link
	logic              s_cclk;
	logic              s_cclk_c;
	logic              s_sclk;
	logic              s_sclk_c;
	logic              s_cs_n;
	logic              s_we_n;
	logic              s_ref_n;
	logic [BANK_W-1:0] s_bank;
	logic [ADDR_W-1:0] s_addr;
	logic [DATA_W-1:0] s_data;
	logic              s_mask;

	// decoded events
	logic              cclk_rise;
	logic              sclk_edge;
	micp_cmd_t         kind;
	logic              mismatch;

	// command side state
	logic              cmd_valid_reg, cmd_valid_next;
	micp_cmd_t         cmd_kind_reg, cmd_kind_next;
	logic [BANK_W-1:0] cmd_bank_reg, cmd_bank_next;
	logic [ADDR_W-1:0] cmd_row_col_reg, cmd_row_col_next;
	logic              cfg_load_reg, cfg_load_next;
	logic [ADDR_W-1:0] cfg_reg, cfg_next;

	// write burst state
	micp_wstate_t      wstate_reg, wstate_next;
	logic [BC_W-1:0]   wleft_reg, wleft_next;
	logic [BANK_W-1:0] wbank_reg, wbank_next;
	logic [ADDR_W-1:0] waddr_reg, waddr_next;
	logic              wbeat_valid_reg, wbeat_valid_next;
	logic              wbeat_store_reg, wbeat_store_next;
	logic [DATA_W-1:0] wbeat_data_reg, wbeat_data_next;
	logic [BC_W-1:0]   wbeat_index_reg, wbeat_index_next;

	// clock pair watchdog
	logic [FC_W-1:0]   mis_cnt_reg, mis_cnt_next;
	logic              fault_reg, fault_next;

	// every link pin passes the same two stages, so data keeps its place
	// relative to the clock edges; costs two cycles of latency
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else if (ce) begin
			sync1_reg <= {link.cmd_clock_true, link.cmd_clock_comp,
				link.wdata_strobe_clock, link.wdata_strobe_clock_comp,
				link.dev_select_n, link.write_cmd_n, link.refresh_cmd_n,
				link.bank_select_lines, link.row_col_select_lines,
				link.write_data_in, link.write_beat_mask};
			sync2_reg <= sync1_reg;
		end
	end

	assign {s_cclk, s_cclk_c, s_sclk, s_sclk_c, s_cs_n, s_we_n, s_ref_n,
		s_bank, s_addr, s_data, s_mask} = sync2_reg;

	// edge finders on the synchronised clocks
	assign cclk_rise = s_cclk && !cclk_prev_reg;
	assign sclk_edge = s_sclk ^ sclk_prev_reg;
	assign kind      = micp_decode({s_cs_n, s_we_n, s_ref_n});
	assign mismatch  = (s_cclk == s_cclk_c) || (s_sclk == s_sclk_c);

	// capture, decode and write beat sampling
	always_comb begin
		cclk_prev_next   = s_cclk;
		sclk_prev_next   = s_sclk;
		cmd_valid_next   = 1'b0;
		cmd_kind_next    = cmd_kind_reg;
		cmd_bank_next    = cmd_bank_reg;
		cmd_row_col_next = cmd_row_col_reg;
		cfg_load_next    = 1'b0;
		cfg_next         = cfg_reg;
		wstate_next      = wstate_reg;
		wleft_next       = wleft_reg;
		wbank_next       = wbank_reg;
		waddr_next       = waddr_reg;
		wbeat_valid_next = 1'b0;
		wbeat_store_next = 1'b0;
		wbeat_data_next  = wbeat_data_reg;
		wbeat_index_next = wbeat_index_reg;
		mis_cnt_next     = mis_cnt_reg;
		fault_next       = fault_reg;

		// a running burst ignores the select line entirely
		if (sclk_edge && (wstate_reg == MICP_WS_BURST)) begin
			wbeat_valid_next = 1'b1;
			wbeat_data_next  = s_data;
			wbeat_store_next = !s_mask;
			wbeat_index_next = BC_W'(WR_BEATS) - wleft_reg;
			wleft_next       = wleft_reg - BC_W'(1);
			if (wleft_reg == BC_W'(1)) begin
				wstate_next = MICP_WS_IDLE;
			end
		end

		// deselected or idle pins decode to no command and leave state alone
		if (cclk_rise && (kind != MICP_NOP)) begin
			cmd_valid_next = 1'b1;
			cmd_kind_next  = kind;
			cmd_bank_next  = s_bank;
			case (kind)
				MICP_READ: begin
					cmd_row_col_next = s_addr;
				end
				MICP_WRITE: begin
					cmd_row_col_next = s_addr;
					// a new write restarts the beat count
					wstate_next      = MICP_WS_BURST;
					wleft_next       = BC_W'(WR_BEATS);
					wbank_next       = s_bank;
					waddr_next       = s_addr;
				end
				MICP_CFG_LOAD: begin
					cfg_next      = s_addr;
					cfg_load_next = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// sticky fault if a clock pair stops being complementary
		if (mismatch) begin
			if (mis_cnt_reg == FC_W'(FAULT_CYC)) begin
				fault_next = 1'b1;
			end else begin
				mis_cnt_next = mis_cnt_reg + FC_W'(1);
			end
		end else begin
			mis_cnt_next = '0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cclk_prev_reg   <= 1'b0;
			sclk_prev_reg   <= 1'b0;
			cmd_valid_reg   <= 1'b0;
			cmd_kind_reg    <= MICP_NOP;
			cmd_bank_reg    <= '0;
			cmd_row_col_reg <= '0;
			cfg_load_reg    <= 1'b0;
			cfg_reg         <= CFG_RST;
			wstate_reg      <= MICP_WS_IDLE;
			wleft_reg       <= '0;
			wbank_reg       <= '0;
			waddr_reg       <= '0;
			wbeat_valid_reg <= 1'b0;
			wbeat_store_reg <= 1'b0;
			wbeat_data_reg  <= '0;
			wbeat_index_reg <= '0;
			mis_cnt_reg     <= '0;
			fault_reg       <= 1'b0;
		end else if (ce) begin
			cclk_prev_reg   <= cclk_prev_next;
			sclk_prev_reg   <= sclk_prev_next;
			cmd_valid_reg   <= cmd_valid_next;
			cmd_kind_reg    <= cmd_kind_next;
			cmd_bank_reg    <= cmd_bank_next;
			cmd_row_col_reg <= cmd_row_col_next;
			cfg_load_reg    <= cfg_load_next;
			cfg_reg         <= cfg_next;
			wstate_reg      <= wstate_next;
			wleft_reg       <= wleft_next;
			wbank_reg       <= wbank_next;
			waddr_reg       <= waddr_next;
			wbeat_valid_reg <= wbeat_valid_next;
			wbeat_store_reg <= wbeat_store_next;
			wbeat_data_reg  <= wbeat_data_next;
			wbeat_index_reg <= wbeat_index_next;
			mis_cnt_reg     <= mis_cnt_next;
			fault_reg       <= fault_next;
		end
	end

	// user side, all from flops
	assign cmd_valid     = cmd_valid_reg;
	assign cmd_kind      = cmd_kind_reg;
	assign cmd_bank      = cmd_bank_reg;
	assign cmd_row_col   = cmd_row_col_reg;
	assign cfg_load      = cfg_load_reg;
	assign cfg_settings  = cfg_reg;
	assign wbeat_valid   = wbeat_valid_reg;
	assign wbeat_store   = wbeat_store_reg;
	assign wbeat_data    = wbeat_data_reg;
	assign wbeat_index   = wbeat_index_reg;
	assign wbeat_bank    = wbank_reg;
	assign wbeat_row_col = waddr_reg;
	assign write_active  = (wstate_reg == MICP_WS_BURST);
	assign clk_fault     = fault_reg;
endmodule
`default_nettype wire

/* File: testbench/micp_link_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module micp_link_assertions #(
	parameter int QTR_CYC = 4
) (
	input wire logic                        clk_sys,
	input wire logic                        arst_n,
	input wire logic                        cmd_clock_true,
	input wire logic                        cmd_clock_comp,
	input wire logic                        wdata_strobe_clock,
	input wire logic                        wdata_strobe_clock_comp,
	input wire logic [micp_pkg::ADDR_W-1:0] row_col_select_lines,
	input wire logic [micp_pkg::BANK_W-1:0] bank_select_lines,
	input wire logic                        dev_select_n,
	input wire logic                        write_cmd_n,
	input wire logic                        refresh_cmd_n,
	input wire logic [micp_pkg::DATA_W-1:0] write_data_in,
	input wire logic                        write_beat_mask
);
	import micp_pkg::*;
	localparam int HALF = 2 * QTR_CYC;
	localparam int PER  = 4 * QTR_CYC;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	// wire-level relations the controller end must keep
	a_cmd_clk_pair: assert property (cmd_clock_comp == ~cmd_clock_true)
		else $error("command clock halves not opposite");
	a_strobe_pair: assert property (wdata_strobe_clock_comp == ~wdata_strobe_clock)
		else $error("strobe halves not opposite");
	a_cmd_word_steady: assert property ($rose(cmd_clock_true) |->
		$stable({row_col_select_lines, bank_select_lines, dev_select_n, write_cmd_n,
		refresh_cmd_n}) ##1 $stable(row_col_select_lines)) else $error("command word moved at clock rise");
	a_cmd_clk_half: assert property ($rose(cmd_clock_true) |-> ##HALF $fell(cmd_clock_true))
		else $error("command clock high time wrong");
	a_strobe_lag: assert property ($rose(cmd_clock_true) && !dev_select_n && !write_cmd_n
		&& refresh_cmd_n |-> ##QTR_CYC $rose(wdata_strobe_clock)) else $error("strobe not a quarter late");
	a_beat_at_rise: assert property ($rose(wdata_strobe_clock) |->
		$stable({write_data_in, write_beat_mask})) else $error("beat moved at strobe rise");
	a_beat_at_fall: assert property ($fell(wdata_strobe_clock) |->
		$stable({write_data_in, write_beat_mask})) else $error("beat moved at strobe fall");
	// back-to-back commands keep select low, so check centring, not release
	a_select_centred: assert property ($fell(dev_select_n) |-> ##HALF ($rose(cmd_clock_true)
		&& !dev_select_n)) else $error("select not centred on command clock rise");

	// main traffic kinds seen on the wire
	c_write: cover property ($rose(cmd_clock_true) && !dev_select_n && !write_cmd_n && refresh_cmd_n);
	c_cfg: cover property ($rose(cmd_clock_true) && !dev_select_n && !write_cmd_n && !refresh_cmd_n);
	c_masked: cover property ($fell(wdata_strobe_clock) && write_beat_mask);
endmodule
`default_nettype wire

/* File: testbench/memory_input_capture_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module memory_input_capture_port_tb_top;
	import micp_pkg::*;
	localparam int QC = 4;
	logic              clk_sys, arst_n, ce, req_valid, req_ready, busy, cmd_valid, cfg_load;
	logic              wbeat_valid, wbeat_store, write_active, clk_fault, fault_b, cmd_b, seen_b;
	micp_cmd_t         req_kind, cmd_kind;
	logic [BANK_W-1:0] req_bank, cmd_bank, wbeat_bank;
	logic [ADDR_W-1:0] req_addr, cmd_row_col, cfg_settings, wbeat_row_col, last_rc;
	logic [35:0]       req_wdata;
	logic [1:0]        req_wmask, wbeat_index, bidx;
	logic [DATA_W-1:0] wbeat_data;
	logic [24:0]       wr_loc;
	logic [27:0]       e, eq[$];
	logic [18:0]       b, bq[$];
	logic [63:0]       r;
	int                err_count, num_checks, seed, i;

	micp_link_if link ();
	micp_link_if link_b ();
	micp_ctrl_end #(.QTR_CYC(QC), .WR_BEATS(2)) i_micp_ctrl_end (.clk_sys(clk_sys),
		.arst_n(arst_n), .ce(ce), .req_valid(req_valid), .req_ready(req_ready),
		.req_kind(req_kind), .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_wmask(req_wmask), .busy(busy), .link(link.ctrl));
	micp_mem_end #(.WR_BEATS(2), .FAULT_CYC(4)) i_micp_mem_end (.clk_sys(clk_sys),
		.arst_n(arst_n), .ce(ce), .link(link.mem), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
		.cmd_bank(cmd_bank), .cmd_row_col(cmd_row_col), .cfg_load(cfg_load),
		.cfg_settings(cfg_settings), .wbeat_valid(wbeat_valid), .wbeat_store(wbeat_store),
		.wbeat_data(wbeat_data), .wbeat_index(wbeat_index), .wbeat_bank(wbeat_bank),
		.wbeat_row_col(wbeat_row_col), .write_active(write_active), .clk_fault(clk_fault));
	// second memory end facing a bench driver that breaks the clock pairing
	micp_mem_end #(.WR_BEATS(2), .FAULT_CYC(4)) i_micp_mem_end_b (.clk_sys(clk_sys),
		.arst_n(arst_n), .ce(ce), .link(link_b.mem), .cmd_valid(cmd_b), .cmd_kind(),
		.cmd_bank(), .cmd_row_col(), .cfg_load(), .cfg_settings(), .wbeat_valid(),
		.wbeat_store(), .wbeat_data(), .wbeat_index(), .wbeat_bank(), .wbeat_row_col(),
		.write_active(), .clk_fault(fault_b));
	micp_link_assertions #(.QTR_CYC(QC)) i_micp_link_assertions (.clk_sys(clk_sys),
		.arst_n(arst_n), .cmd_clock_true(link.cmd_clock_true),
		.cmd_clock_comp(link.cmd_clock_comp), .wdata_strobe_clock(link.wdata_strobe_clock),
		.wdata_strobe_clock_comp(link.wdata_strobe_clock_comp),
		.row_col_select_lines(link.row_col_select_lines),
		.bank_select_lines(link.bank_select_lines), .dev_select_n(link.dev_select_n),
		.write_cmd_n(link.write_cmd_n), .refresh_cmd_n(link.refresh_cmd_n),
		.write_data_in(link.write_data_in), .write_beat_mask(link.write_beat_mask));

	// system clock, 4 ns
	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// only reads and writes carry a row/column location
	function automatic logic is_access(input logic [2:0] k);
		return (k == MICP_READ) || (k == MICP_WRITE);
	endfunction

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// offer one request and hold it until the ready edge; nop is sent as deselect
	task automatic send(input micp_cmd_t k, input logic [2:0] bk, input logic [21:0] a,
			input logic [35:0] d, input logic [1:0] m);
		int n;
		n = 0;
		@(negedge clk_sys);
		req_kind = k;
		req_bank = bk;
		req_addr = a;
		req_wdata = d;
		req_wmask = m;
		req_valid = 1;
		while (req_ready !== 1'b1 && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 200) chk(1, 0);
		if (k != MICP_NOP) eq.push_back({k, bk, a});
		if (k == MICP_WRITE) begin
			bq.push_back({m[0], d[17:0]});
			bq.push_back({m[1], d[35:18]});
		end
		@(negedge clk_sys);
		chk(busy, k == MICP_WRITE);
		req_valid = 0;
	endtask

	// scoreboard: decoded commands and beats against what was offered
	always @(posedge clk_sys) begin
		if (arst_n && cmd_b) seen_b <= 1;
		if (arst_n && cmd_valid) begin
			e = eq.size() ? eq.pop_front() : 28'hfffffff;
			chk({cmd_kind, cmd_bank}, e[27:22]);
			chk(cfg_load, e[27:25] == MICP_CFG_LOAD);
			chk(write_active, e[27:25] == MICP_WRITE);
			if (cfg_load) chk(cfg_settings, e[21:0]);
			if (is_access(e[27:25])) last_rc = e[21:0];
			if (!cfg_load) chk(cmd_row_col, last_rc);
			if (e[27:25] == MICP_WRITE) wr_loc = e[24:0];
			bidx = 0;
		end
		if (arst_n && wbeat_valid) begin
			b = bq.size() ? bq.pop_front() : 19'h7ffff;
			chk(wbeat_data, b[17:0]);
			chk(wbeat_store, !b[18]);
			chk(wbeat_index, bidx);
			chk({wbeat_bank, wbeat_row_col}, wr_loc);
			bidx = bidx + 2'h1;
		end
	end

	// watchdog well beyond the expected run
	initial begin
		#100000;
		err_count++;
		give_verdict();
	end

	initial begin
		seed = 48531;
		{req_bank, req_addr, req_wdata, req_wmask} = '0;
		req_kind = MICP_NOP;
		req_valid = 0;
		ce = 1;
		arst_n = 0;
		seen_b = 0;
		last_rc = '0;
		{link_b.cmd_clock_true, link_b.wdata_strobe_clock, link_b.row_col_select_lines} = '0;
		{link_b.bank_select_lines, link_b.write_data_in, link_b.write_beat_mask} = '0;
		{link_b.cmd_clock_comp, link_b.wdata_strobe_clock_comp, link_b.dev_select_n} = 3'h7;
		{link_b.write_cmd_n, link_b.refresh_cmd_n} = 2'h3;
		repeat (10) @(negedge clk_sys);
		arst_n = 1;
		// corner cases: every kind, extreme fields, masked beats
		send(MICP_CFG_LOAD, 3'h7, 22'h3fffff, 36'h0, 2'h0);
		send(MICP_WRITE, 3'h0, 22'h000000, 36'hfffff0001, 2'h2);
		send(MICP_NOP, 3'h5, 22'h155555, 36'h0, 2'h0);
		send(MICP_WRITE, 3'h7, 22'h3fffff, 36'h0aaaa5555, 2'h1);
		send(MICP_REFRESH, 3'h3, 22'h2aaaaa, 36'h0, 2'h0);
		send(MICP_READ, 3'h4, 22'h12345, 36'h0, 2'h0);
		$display("corner test done");
		// random traffic
		for (i = 0; i < 60; i++) begin
			r = {$random(seed), $random(seed)};
			send(micp_cmd_t'(r[63:61] % 3'h5), r[60:58], r[57:36], r[35:0], r[37:36]);
		end
		repeat (60) @(negedge clk_sys);
		chk(eq.size() + bq.size(), 0);
		chk(clk_fault, 0);
		$display("random test done");
		// bench link clock at 125 ns, deselected commands, then comp half left stuck
		#0.25; // keeps every link change off the clk_sys rising edges
		for (i = 0; i < 40; i++) begin
			#62.5 link_b.cmd_clock_true = ~link_b.cmd_clock_true;
			if (i < 20) link_b.cmd_clock_comp = ~link_b.cmd_clock_true;
			link_b.write_cmd_n = i[1];
			link_b.refresh_cmd_n = i[2];
			if (i == 19) chk(fault_b, 0);
		end
		#100;
		chk(fault_b, 1);
		chk(seen_b, 0);
		$display("fault test done");
		give_verdict();
	end
endmodule
`default_nettype wire
